/* serial_host_pkg.sv */
// Constants shared by the two-channel serial host interface
package serial_host_pkg;
  // -----------------------------------------------------------------
  // Register pointers and commands
  // -----------------------------------------------------------------
  localparam logic [2:0] PTR_BASE = 3'h0;
  localparam logic [2:0] PTR_INT_ENABLE = 3'h1;
  localparam logic [2:0] PTR_VECTOR_MODE = 3'h2;
  localparam logic [2:0] PTR_RECEIVER = 3'h3;
  localparam logic [2:0] PTR_FORMAT = 3'h4;
  localparam logic [2:0] PTR_TRANSMITTER = 3'h5;
  localparam logic [2:0] PTR_STATUS_ERR = 3'h1;
  localparam logic [2:0] PTR_STATUS_VEC = 3'h2;
  // Base-register command field, bits 5:3
  localparam int CMD_LSB = 3;
  localparam logic [2:0] CMD_NULL = 3'h0;
  localparam logic [2:0] CMD_RESET_EXT = 3'h2;
  localparam logic [2:0] CMD_CHANNEL_RESET = 3'h3;
  localparam logic [2:0] CMD_ERROR_RESET = 3'h6;
  localparam logic [2:0] CMD_END_OF_INT = 3'h7;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int FMT_DIV_LSB = 6;
  localparam int FMT_STOP_LSB = 2;
  localparam int FMT_PAR_EVEN = 1;
  localparam int FMT_PAR_EN = 0;
  localparam logic [1:0] DIV_X16 = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h3;
  localparam int RXC_LEN_LSB = 6;
  localparam int RXC_AUTO = 5;
  localparam int RXC_EN = 0;
  localparam int TXC_DTR = 7;
  localparam int TXC_LEN_LSB = 5;
  localparam int TXC_BREAK = 4;
  localparam int TXC_EN = 3;
  localparam int TXC_RTS = 1;
  localparam int MODE_VIM_LSB = 3;
  localparam int MODE_PRIO = 2;
  localparam int MODE_CFG_LSB = 0;
  localparam int IE_RX_LSB = 3;
  localparam int IE_SAV = 2;
  localparam int IE_TX = 1;
  localparam int IE_EXT = 0;
  localparam logic [1:0] RXI_OFF = 2'h0;
  localparam int ERR_PARITY = 4;
  localparam int ERR_OVERRUN = 5;
  localparam int ERR_FRAMING = 6;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONES8 = 8'hff;
  localparam int OVERSAMPLE = 16;
  // Vector low-bit codes, channel B then channel A
  localparam logic [2:0] VEC_TX = 3'h0;
  localparam logic [2:0] VEC_EXT = 3'h1;
  localparam logic [2:0] VEC_RX = 3'h2;
  localparam logic [2:0] VEC_ERR = 3'h3;
  localparam logic [2:0] VEC_NONE = 3'h7;
  localparam logic [2:0] VEC_CHA = 3'h4;
endpackage : serial_host_pkg

/* dual_async_serial_host_interface.sv */
// Two-channel async serial controller: host registers and interrupt logic
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - One direct command register per channel; five others via its pointer.
// - Select low picks data/command, select high picks channel A/B.
// - Single active-low interrupt request output.
// - Acknowledge cycle puts the applicable vector on the data bus.
// - Up to eight vectors from transfer, status and error conditions.
// - Base vector is programmable by software.
// - Channel B vector register holds 8 bits; low bits vary by condition.
// - Format: divisor 7:6, stop bits 3:2, parity sense 1, parity enable 0.
// - Receiver: length 7:6, auto enable 5, receiver enable 0.
// - Transmitter: DTR 7, length 6:5, break 4, enable 3, RTS 1.
// - Mode: vectored mode 5:3, priority 2, configuration 1:0.
// - Enables: receive mode 4:3, status-affects-vector 2, transmit 1, external 0.
// - Sixteen-times baud clock selected by divisor field.
// - Supports 8 data bits, no parity, two stop bits.
// - Interrupt on every received character with variable vector.
// - Transmit interrupt raised when buffer becomes empty, not while empty.
// - End-of-interrupt clears serviced vector, lets other requests through.
// - Parity, overrun, framing errors give error vector and error status.
module dual_async_serial_host_interface
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipSelect_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic register_select_low,
  input wire logic register_select_high,
  input wire logic interrupt_acknowledge_n,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOutEnable,
  input wire logic [1:0] rxValid,
  input wire logic [15:0] rxData,
  input wire logic [1:0] rxParityErr,
  input wire logic [1:0] rxFramingErr,
  input wire logic [1:0] txBusy,
  input wire logic [1:0] extChange,
  output logic [1:0] txLoad,
  output logic [15:0] txData,
  output logic [7:0] charFormatA,
  output logic [7:0] charFormatB,
  output logic [7:0] rxControlA,
  output logic [7:0] rxControlB,
  output logic [7:0] txControlA,
  output logic [7:0] txControlB,
  output logic [1:0] baudX16,
  output logic interrupt_request_n
);
  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  logic wrStrobe;
  logic rdStrobe;
  logic ackCycle;
  logic writeSeen_q;
  logic chan;
  assign chan = register_select_high; // 0 = A, 1 = B
  // One action per write cycle, on its first clock
  assign wrStrobe = !chipSelect_n && !write_n && !writeSeen_q;
  assign rdStrobe = !chipSelect_n && !read_n;
  assign ackCycle = !interrupt_acknowledge_n;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      writeSeen_q <= 1'b0;
    else
      writeSeen_q <= !chipSelect_n && !write_n;
  end
  // -----------------------------------------------------------------
  // Write registers, per channel
  // -----------------------------------------------------------------
  logic [2:0] pointer_q [2];
  logic [7:0] intEnable_q [2];
  logic [7:0] rxCtl_q [2];
  logic [7:0] fmt_q [2];
  logic [7:0] txCtl_q [2];
  logic [7:0] vectorBase_q;
  logic [7:0] intMode_q;
  logic [1:0] endIntPulse;
  logic [1:0] errReset;
  logic [1:0] chanReset;
  logic cmdWrite;
  logic [2:0] cmdCode;
  assign cmdWrite = wrStrobe && register_select_low;
  assign cmdCode = dataIn[serial_host_pkg::CMD_LSB+:3];
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic isBase;
    assign isBase = (pointer_q[c] == serial_host_pkg::PTR_BASE);
    assign endIntPulse[c] = cmdWrite && chan == c[0] && isBase
                         && cmdCode == serial_host_pkg::CMD_END_OF_INT;
    assign errReset[c] = cmdWrite && chan == c[0] && isBase
                         && cmdCode == serial_host_pkg::CMD_ERROR_RESET;
    assign chanReset[c] = cmdWrite && chan == c[0] && isBase
                          && cmdCode == serial_host_pkg::CMD_CHANNEL_RESET;
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || chanReset[c])
      begin
        pointer_q[c] <= serial_host_pkg::PTR_BASE;
        intEnable_q[c] <= serial_host_pkg::ZERO8;
        rxCtl_q[c] <= serial_host_pkg::ZERO8;
        fmt_q[c] <= serial_host_pkg::ZERO8;
        txCtl_q[c] <= serial_host_pkg::ZERO8;
      end
      else if (cmdWrite && chan == c[0])
      begin
        if (isBase)
          pointer_q[c] <= dataIn[2:0];
        else
        begin
          pointer_q[c] <= serial_host_pkg::PTR_BASE;
          case (pointer_q[c])
            serial_host_pkg::PTR_INT_ENABLE: intEnable_q[c] <= dataIn;
            serial_host_pkg::PTR_RECEIVER: rxCtl_q[c] <= dataIn;
            serial_host_pkg::PTR_FORMAT: fmt_q[c] <= dataIn;
            serial_host_pkg::PTR_TRANSMITTER: txCtl_q[c] <= dataIn;
            default: ;
          endcase
        end
      end
      else if (rdStrobe && register_select_low && chan == c[0] && !isBase)
        pointer_q[c] <= serial_host_pkg::PTR_BASE;
    end
  end
  // Shared vector/mode register: B holds vector, A holds mode
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      vectorBase_q <= serial_host_pkg::ZERO8;
      intMode_q <= serial_host_pkg::ZERO8;
    end
    else if (cmdWrite && pointer_q[chan] == serial_host_pkg::PTR_VECTOR_MODE)
    begin
      if (chan)
        vectorBase_q <= dataIn;
      else
        intMode_q <= dataIn;
    end
  end
  // -----------------------------------------------------------------
  // Pending conditions
  // -----------------------------------------------------------------
  // Index: bit 0 tx, 1 ext, 2 rx, 3 err, per channel
  logic [3:0] pend_q [2];
  logic [7:0] errStat_q [2];
  logic [7:0] rxHold_q [2];
  logic [1:0] rxFull_q;
  logic [1:0] txBusyPrev_q;
  logic [1:0] inService_q;
  logic [1:0] txWrite;
  logic [1:0] rxRead;

  for (genvar c = 0; c < 2; c++)
  begin : g_pend
    logic txEmptied;
    logic rxIe;
    logic overrun;
    logic anyErr;
    assign txWrite[c] = wrStrobe && !register_select_low && chan == c[0];
    assign rxRead[c] = rdStrobe && !register_select_low && chan == c[0];
    assign txEmptied = txBusyPrev_q[c] && !txBusy[c];
    assign rxIe = intEnable_q[c][serial_host_pkg::IE_RX_LSB+:2] != serial_host_pkg::RXI_OFF;
    assign overrun = rxValid[c] && rxFull_q[c] && !rxRead[c];
    assign anyErr = rxValid[c] && (rxParityErr[c] || rxFramingErr[c] || overrun);
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || chanReset[c])
        txBusyPrev_q[c] <= 1'b0;
      else
        txBusyPrev_q[c] <= txBusy[c];
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || chanReset[c])
      begin
        rxHold_q[c] <= serial_host_pkg::ZERO8;
        rxFull_q[c] <= 1'b0;
      end
      else if (rxValid[c])
      begin
        rxHold_q[c] <= rxData[8*c+:8];
        rxFull_q[c] <= 1'b1;
      end
      else if (rxRead[c])
        rxFull_q[c] <= 1'b0;
    end
    // Latched errors; a new error wins over the reset command
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || chanReset[c])
        errStat_q[c] <= serial_host_pkg::ZERO8;
      else
      begin
        errStat_q[c][serial_host_pkg::ERR_PARITY] <= (rxValid[c] && rxParityErr[c])
          || (errStat_q[c][serial_host_pkg::ERR_PARITY] && !errReset[c]);
        errStat_q[c][serial_host_pkg::ERR_OVERRUN] <= overrun
          || (errStat_q[c][serial_host_pkg::ERR_OVERRUN] && !errReset[c]);
        errStat_q[c][serial_host_pkg::ERR_FRAMING] <= (rxValid[c] && rxFramingErr[c])
          || (errStat_q[c][serial_host_pkg::ERR_FRAMING] && !errReset[c]);
      end
    end
    // Set wins over clear; each source is cleared by its own host action
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n || chanReset[c])
        pend_q[c] <= 4'h0;
      else
      begin
        pend_q[c][0] <= (txEmptied && intEnable_q[c][serial_host_pkg::IE_TX])
                        || (pend_q[c][0] && !txWrite[c]);
        pend_q[c][1] <= (extChange[c] && intEnable_q[c][serial_host_pkg::IE_EXT])
                        || (pend_q[c][1] && !(cmdWrite && chan == c[0]
                        && pointer_q[c] == serial_host_pkg::PTR_BASE
                        && cmdCode == serial_host_pkg::CMD_RESET_EXT));
        pend_q[c][2] <= (rxValid[c] && rxIe && !anyErr)
                        || (pend_q[c][2] && !rxRead[c]);
        pend_q[c][3] <= (anyErr && rxIe) || (pend_q[c][3] && !errReset[c]);
      end
    end
  end

  // -----------------------------------------------------------------
  // Interrupt arbitration and vector
  // -----------------------------------------------------------------
  function automatic logic [2:0] pickCode(input logic [3:0] p);
    logic [2:0] code;
    code = serial_host_pkg::VEC_NONE;
    if (p[3])
      code = serial_host_pkg::VEC_ERR;
    else if (p[2])
      code = serial_host_pkg::VEC_RX;
    else if (p[0])
      code = serial_host_pkg::VEC_TX;
    else if (p[1])
      code = serial_host_pkg::VEC_EXT;
    return code;
  endfunction : pickCode

  logic [2:0] winCode;
  logic anyPend;
  logic winChan;
  assign anyPend = (|pend_q[0]) || (|pend_q[1]);
  // Channel A outranks B
  assign winChan = !(|pend_q[0]);
  assign winCode = !anyPend ? serial_host_pkg::VEC_NONE
                 : winChan ? pickCode(pend_q[1])
                 : (pickCode(pend_q[0]) | serial_host_pkg::VEC_CHA);
  logic [7:0] vectorNow;
  always_comb
  begin
    vectorNow = vectorBase_q;
    if (intEnable_q[1][serial_host_pkg::IE_SAV])
      vectorNow[2:0] = winCode;
  end
  // Hold request off while a vector is in service, until end of interrupt
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      inService_q <= 2'h0;
    else if (ackCycle && anyPend)
      inService_q <= {winChan, !winChan};
    else if (|endIntPulse)
      inService_q <= 2'h0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      interrupt_request_n <= 1'b1;
    else
      interrupt_request_n <= !(anyPend && !(|inService_q));
  end
  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dataOut <= serial_host_pkg::ZERO8;
      dataOutEnable <= 1'b0;
    end
    else
    begin
      dataOutEnable <= rdStrobe || ackCycle;
      if (ackCycle)
        dataOut <= vectorNow;
      else if (!register_select_low)
        dataOut <= rxHold_q[chan];
      else if (pointer_q[chan] == serial_host_pkg::PTR_STATUS_ERR)
        dataOut <= errStat_q[chan];
      else if (pointer_q[chan] == serial_host_pkg::PTR_STATUS_VEC && chan)
        dataOut <= vectorNow;
      else
        dataOut <= {5'h00, !txBusy[chan], 1'b0, rxFull_q[chan]};
    end
  end
  // -----------------------------------------------------------------
  // Outputs to the serial engines
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      txLoad <= 2'h0;
      txData <= 16'h0000;
      charFormatA <= serial_host_pkg::ZERO8;
      charFormatB <= serial_host_pkg::ZERO8;
      rxControlA <= serial_host_pkg::ZERO8;
      rxControlB <= serial_host_pkg::ZERO8;
      txControlA <= serial_host_pkg::ZERO8;
      txControlB <= serial_host_pkg::ZERO8;
      baudX16 <= 2'h0;
    end
    else
    begin
      txLoad <= txWrite;
      if (|txWrite)
        txData <= {dataIn, dataIn};
      charFormatA <= fmt_q[0];
      charFormatB <= fmt_q[1];
      rxControlA <= rxCtl_q[0];
      rxControlB <= rxCtl_q[1];
      txControlA <= txCtl_q[0];
      txControlB <= txCtl_q[1];
      baudX16 <= {fmt_q[1][serial_host_pkg::FMT_DIV_LSB+:2] == serial_host_pkg::DIV_X16,
                  fmt_q[0][serial_host_pkg::FMT_DIV_LSB+:2] == serial_host_pkg::DIV_X16};
    end
  end
endmodule : dual_async_serial_host_interface
`default_nettype wire

/* dual_async_serial_host_interface_monitor.sv */
// Port-level assertion checker for the serial host interface
`timescale 1ns/10ps
`default_nettype none
module dual_async_serial_host_interface_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipSelect_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic register_select_low,
  input wire logic interrupt_acknowledge_n,
  input wire logic dataOutEnable,
  input wire logic [1:0] txLoad,
  input wire logic [15:0] txData,
  input wire logic [7:0] charFormatA,
  input wire logic [1:0] baudX16,
  input wire logic interrupt_request_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ------
  // Bus history, a write may land up to three edges late
  // ------
  logic anyWr;
  logic dataWr;
  logic busRd;
  logic [3:0] wrHist_q;
  logic [3:0] dataHist_q;
  assign anyWr = !chipSelect_n && !write_n;
  assign dataWr = anyWr && !register_select_low;
  assign busRd = (!chipSelect_n && !read_n) || !interrupt_acknowledge_n;
  always_ff @(posedge ref_clk)
  begin
    wrHist_q <= rst_n ? {wrHist_q[2:0], anyWr} : 4'h0;
    dataHist_q <= rst_n ? {dataHist_q[2:0], dataWr} : 4'h0;
  end
  reset_idle_a: assert property ($rose(rst_n) |-> interrupt_request_n && !dataOutEnable)
    else $error("outputs busy after reset");
  read_answer_a: assert property (!chipSelect_n && !read_n |-> ##[1:2] dataOutEnable)
    else $error("read not answered");
  ack_answer_a: assert property (!interrupt_acknowledge_n |-> ##[1:2] dataOutEnable)
    else $error("no vector on acknowledge");
  drive_cause_a: assert property (dataOutEnable |-> $past(busRd) || $past(busRd, 2))
    else $error("bus driven without read");
  load_cause_a: assert property (|txLoad |-> |dataHist_q[2:0])
    else $error("load without data write");
  load_pulse_a: assert property (|txLoad |-> txData[7:0] == txData[15:8] ##1 !txLoad)
    else $error("load pulse malformed");
  config_write_a: assert property ($changed(charFormatA) |-> |wrHist_q)
    else $error("format changed without write");
  baud_follow_a: assert property ($changed(charFormatA) |-> ##[0:2]
    baudX16[0] == (charFormatA[7:6] == serial_host_pkg::DIV_X16))
    else $error("baud select wrong");
  served_high_a: assert property (!interrupt_acknowledge_n [*2] |-> ##2 interrupt_request_n [*2])
    else $error("request low while in service");
  cover property ($fell(interrupt_request_n));
  cover property (!interrupt_acknowledge_n ##1 dataOutEnable);
  cover property (|txLoad);
endmodule : dual_async_serial_host_interface_monitor
bind dual_async_serial_host_interface dual_async_serial_host_interface_monitor mon (.ref_clk,
  .rst_n, .chipSelect_n, .read_n, .write_n, .register_select_low, .interrupt_acknowledge_n,
  .dataOutEnable, .txLoad, .txData, .charFormatA, .baudX16, .interrupt_request_n);
`default_nettype wire

/* host_bus_model.sv */
// Host processor model on the parallel peripheral bus
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input wire logic ref_clk,
  output logic chipSelect_n,
  output logic read_n,
  output logic write_n,
  output logic register_select_low,
  output logic register_select_high,
  output logic interrupt_acknowledge_n,
  output logic [7:0] dataIn,
  input wire logic [7:0] dataOut
);
  initial
  begin
    {chipSelect_n, read_n, write_n, interrupt_acknowledge_n} = 4'hf;
    {register_select_high, register_select_low} = 2'h0;
    dataIn = 8'h00;
  end
  // One write per low period of the strobe
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge ref_clk);
    {register_select_high, register_select_low} = sel;
    dataIn = d;
    {chipSelect_n, write_n} = 2'h0;
    @(negedge ref_clk);
    {chipSelect_n, write_n} = 2'h3;
    // Released bus never shows the stale byte
    dataIn = ~d;
  endtask : wr
  task automatic ptrWr(input logic [1:0] sel, input logic [2:0] p, input logic [7:0] d);
    wr(sel, {5'h00, p});
    wr(sel, d);
  endtask : ptrWr
  // Held over two edges; answer taken before release
  task automatic rd(input logic [1:0] sel, input logic ack, output logic [7:0] d);
    @(negedge ref_clk);
    {register_select_high, register_select_low} = sel;
    if (ack)
      interrupt_acknowledge_n = 1'b0;
    else
      {chipSelect_n, read_n} = 2'h0;
    // First edge's answer; a command read moves the pointer on that same edge
    @(negedge ref_clk);
    d = dataOut;
    @(negedge ref_clk);
    {chipSelect_n, read_n, interrupt_acknowledge_n} = 3'h7;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

/* dual_async_serial_host_interface_tb.sv */
// Self-checking testbench for the serial host interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin numChecks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module dual_async_serial_host_interface_tb;
  localparam logic [7:0] END_INT_CMD = {2'h0, serial_host_pkg::CMD_END_OF_INT, 3'h0};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] rxValid = 2'h0;
  logic [15:0] rxData = 16'h0000;
  logic [1:0] rxParityErr = 2'h0;
  logic [1:0] rxFramingErr = 2'h0;
  logic [1:0] txBusy = 2'h0;
  logic [1:0] extChange = 2'h0;
  logic chipSelect_n, read_n, write_n, register_select_low, register_select_high;
  logic interrupt_acknowledge_n, dataOutEnable, interrupt_request_n;
  logic [7:0] dataIn, dataOut, charFormatA, charFormatB, rxControlA, rxControlB;
  logic [7:0] txControlA, txControlB, v, lastTx;
  logic [15:0] txData;
  logic [1:0] txLoad, baudX16;
  int fails = 0;
  int numChecks = 0;
  int cycles = 0;
  int loads = 0;
  always #20 ref_clk = ~ref_clk;
  dual_async_serial_host_interface dut (.ref_clk, .rst_n, .chipSelect_n, .read_n, .write_n,
    .register_select_low, .register_select_high, .interrupt_acknowledge_n, .dataIn, .dataOut,
    .dataOutEnable, .rxValid, .rxData, .rxParityErr, .rxFramingErr, .txBusy, .extChange,
    .txLoad, .txData, .charFormatA, .charFormatB, .rxControlA, .rxControlB, .txControlA,
    .txControlB, .baudX16, .interrupt_request_n);
  host_bus_model host (.ref_clk, .chipSelect_n, .read_n, .write_n, .register_select_low,
    .register_select_high, .interrupt_acknowledge_n, .dataIn, .dataOut);
  always @(posedge ref_clk)
  begin
    cycles++;
    if (txLoad[1] === 1'b1)
    begin
      loads++;
      lastTx = txData[15:8];
    end
    if (cycles == 4000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask : settle
  task automatic waitIrq();
    for (int i = 0; i < 6 && interrupt_request_n !== 1'b0; i++)
      @(negedge ref_clk);
  endtask : waitIrq
  task automatic pulseRx(input int ch, input logic [7:0] d, input logic err);
    @(negedge ref_clk);
    rxValid[ch] = 1'b1;
    rxData[ch*8 +: 8] = d;
    rxParityErr[ch] = err;
    rxFramingErr[ch] = err;
    @(negedge ref_clk);
    {rxValid, rxParityErr, rxFramingErr} = 6'h00;
  endtask : pulseRx
  task automatic testRegs();
    `CHK("irq idle", 1'b1, interrupt_request_n)
    host.ptrWr(2'h1, 3'h4, 8'h4c);
    host.ptrWr(2'h3, 3'h4, 8'h8d);
    host.ptrWr(2'h1, 3'h3, 8'he1);
    host.ptrWr(2'h3, 3'h3, 8'h40);
    host.ptrWr(2'h1, 3'h5, 8'hea);
    host.ptrWr(2'h3, 3'h5, 8'h12);
    host.ptrWr(2'h1, 3'h6, 8'hff);
    settle();
    `CHK("fmtA", 8'h4c, charFormatA)
    `CHK("fmtB", 8'h8d, charFormatB)
    `CHK("baud", 2'h1, baudX16)
    `CHK("rxA", 8'he1, rxControlA)
    `CHK("rxB", 8'h40, rxControlB)
    `CHK("txA", 8'hea, txControlA)
    `CHK("txB", 8'h12, txControlB)
    host.ptrWr(2'h1, 3'h4, 8'h03);
    host.ptrWr(2'h1, 3'h3, 8'h41);
    settle();
    `CHK("fmt kept", 8'h03, charFormatA)
    `CHK("rx ptr", 8'h41, rxControlA)
    $display("test registers done");
  endtask : testRegs
  task automatic testRx();
    host.ptrWr(2'h3, 3'h2, 8'h80);
    host.ptrWr(2'h1, 3'h2, 8'h10);
    host.ptrWr(2'h3, 3'h1, 8'h0c);
    host.ptrWr(2'h1, 3'h1, 8'h08);
    pulseRx(1, 8'h5a, 1'b0);
    waitIrq();
    `CHK("rx irq", 1'b0, interrupt_request_n)
    host.rd(2'h0, 1'b1, v);
    `CHK("rx vec", {5'h10, serial_host_pkg::VEC_RX}, v)
    `CHK("served", 1'b1, interrupt_request_n)
    host.rd(2'h2, 1'b0, v);
    `CHK("rx data", 8'h5a, v)
    host.wr(2'h3, END_INT_CMD);
    settle();
    `CHK("eoi", 1'b1, interrupt_request_n)
    host.wr(2'h3, 8'h02);
    host.rd(2'h3, 1'b0, v);
    `CHK("idle vec", {5'h10, serial_host_pkg::VEC_NONE}, v)
    $display("test receive done");
  endtask : testRx
  task automatic testErr();
    pulseRx(0, 8'h11, 1'b0);
    pulseRx(0, 8'h22, 1'b1);
    waitIrq();
    host.rd(2'h0, 1'b1, v);
    `CHK("err vec", {5'h10, serial_host_pkg::VEC_ERR | serial_host_pkg::VEC_CHA}, v)
    host.wr(2'h1, 8'h01);
    host.rd(2'h1, 1'b0, v);
    `CHK("err bits", 8'h70, v & 8'h70)
    host.rd(2'h0, 1'b0, v);
    host.wr(2'h1, {2'h0, serial_host_pkg::CMD_ERROR_RESET, 3'h0});
    host.wr(2'h1, END_INT_CMD);
    settle();
    `CHK("err done", 1'b1, interrupt_request_n)
    $display("test error done");
  endtask : testErr
  task automatic testTx();
    host.ptrWr(2'h3, 3'h1, 8'h0e);
    settle();
    `CHK("idle empty", 1'b1, interrupt_request_n)
    host.wr(2'h2, 8'hc3);
    settle();
    `CHK("loads", 1, loads)
    `CHK("tx byte", 8'hc3, lastTx)
    txBusy[1] = 1'b1;
    repeat (4) @(negedge ref_clk);
    txBusy[1] = 1'b0;
    waitIrq();
    host.rd(2'h0, 1'b1, v);
    `CHK("tx vec", {5'h10, serial_host_pkg::VEC_TX}, v)
    host.wr(2'h2, 8'h3c);
    host.wr(2'h3, END_INT_CMD);
    settle();
    `CHK("tx done", 1'b1, interrupt_request_n)
    $display("test transmit done");
  endtask : testTx
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    testRegs();
    testRx();
    testErr();
    testTx();
    report_and_stop();
  end
endmodule : dual_async_serial_host_interface_tb
`default_nettype wire
